// ===== shared/mcs_pkg.sv
// Constants shared by the microphone calibration sequencer
package mcs_pkg;
    // Register offsets
    localparam logic [7:0] ADR_STATUS    = 8'h0e;
    localparam logic [7:0] ADR_BAND      = 8'h0f;
    localparam logic [7:0] ADR_CHAN      = 8'h10;
    localparam logic [7:0] ADR_STORE     = 8'h11;
    localparam logic [7:0] ADR_START     = 8'h12;
    // Field positions
    localparam int START_BIT     = 0;
    localparam int ONE_TONE_BIT  = 1;
    localparam int STROBE_N_BIT  = 7;
    localparam int READY_BIT     = 7;
    // Reset values
    localparam logic [7:0] START_RST = 8'h00;
    localparam logic [7:0] STORE_RST = 8'h80;
    localparam logic [7:0] COMP_RST  = 8'h88;
    localparam logic [6:0] TRIM_RST  = 7'h00;
    // Timing in ms from calibration start
    localparam logic [9:0] T_ST1_MS  = 10'd10;
    localparam logic [9:0] T_ET1_MS  = 10'd200;
    localparam logic [9:0] T_ST2_MS  = 10'd210;
    localparam logic [9:0] T_ET2_MS  = 10'd400;
    localparam logic [9:0] T_ST3_MS  = 10'd410;
    localparam logic [9:0] T_ET3_MS  = 10'd600;
    localparam logic [9:0] T_CC_MS   = 10'd790;
    // Clock and derived cycles per millisecond
    localparam int CLK_PERIOD_PS = 10000;
    localparam int MS_PS         = 1000000000;
    localparam int CYC_PER_MS    = MS_PS / CLK_PERIOD_PS;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE,
        ST_STORE
    } mcs_state_t;
endpackage : mcs_pkg

// ===== shared/mcs_tmr_if.sv
// Link between the sequencer and its millisecond timer
`timescale 1ns/1ps
interface mcs_tmr_if;
    logic       run;
    logic [9:0] ms;
    logic       ms_tick;
    modport tmr (input run, output ms, output ms_tick);
    modport ctl (output run, input ms, input ms_tick);
endinterface : mcs_tmr_if

// ===== logic/mcs_timer.sv
// Millisecond time base counting from calibration start
`timescale 1ns/1ps
module mcs_timer #(
    parameter int CYC_PER_MS = mcs_pkg::CYC_PER_MS
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    mcs_tmr_if.tmr    t
);
    logic [16:0] div;
    logic        wrap;
    assign wrap = (div == 17'(CYC_PER_MS - 1));

    // Divider cleared while idle so every run starts at 0 ms
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !t.run) begin
            div       <= 17'h0;
            t.ms_tick <= 1'b0;
        end else begin
            div       <= wrap ? 17'h0 : div + 17'h1;
            t.ms_tick <= wrap;
        end
    end

    // Saturating ms count; stops short of wrapping back into a window
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !t.run) begin
            t.ms <= 10'h0;
        end else if (t.ms_tick && t.ms != 10'h3ff) begin
            t.ms <= t.ms + 10'h1;
        end
    end
endmodule : mcs_timer

// ===== logic/mcs_top.sv
// Calibration sequencer: start control, tone windows, result store
`timescale 1ns/1ps
module mcs_top #(
    parameter int         CYC_PER_MS = mcs_pkg::CYC_PER_MS,
    parameter logic [6:0] TRIM_INIT  = mcs_pkg::TRIM_RST
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       cal_request_pin,
    input  wire logic       store_permit_pin,
    input  wire logic       aux_programming_pin,
    input  wire logic       meas_valid,
    input  wire logic [7:0] meas_code,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       nvm_prog_done,
    output logic            nvm_prog_start,
    output logic            nvm_write_strobe_n,
    output logic     [15:0] nvm_wr_data,
    output logic            cal_active
);
    mcs_tmr_if tif ();
    mcs_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .t       (tif)
    );

    mcs_pkg::mcs_state_t st;
    mcs_pkg::mcs_state_t next_st;
    logic [7:0] start_ctl;
    logic [7:0] band;
    logic [7:0] chan;
    logic [7:0] store_ctl;
    logic       ready;
    logic [7:0] res_band;
    logic [7:0] res_chan;
    logic       src_pin;
    logic       permit_ok;
    logic       in_store_d;
    logic [2:0] cal_sy;
    logic [1:0] pe_sy;
    logic [1:0] aux_sy;
    logic [2:0] mv_sy;
    logic [7:0] mc_s1;
    logic [7:0] mc_s2;

    // Window test reused for all three tones
    function automatic logic in_win(input logic [9:0] ms,
                                    input logic [9:0] lo,
                                    input logic [9:0] hi);
        in_win = (ms >= lo) && (ms < hi);
    endfunction : in_win

    // Pins and analog estimator are asynchronous: two flops first
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cal_sy <= 3'h0;
            pe_sy  <= 2'h0;
            aux_sy <= 2'h0;
            mv_sy  <= 3'h0;
            mc_s1  <= 8'h00;
            mc_s2  <= 8'h00;
        end else begin
            cal_sy <= {cal_sy[1:0], cal_request_pin};
            pe_sy  <= {pe_sy[0], store_permit_pin};
            aux_sy <= {aux_sy[0], aux_programming_pin};
            mv_sy  <= {mv_sy[1:0], meas_valid};
            mc_s1  <= meas_code;
            mc_s2  <= mc_s1;
        end
    end

    // Decoded strobes and conditions
    wire w_start   = reg_wr && reg_addr == mcs_pkg::ADR_START;
    wire w_band    = reg_wr && reg_addr == mcs_pkg::ADR_BAND;
    wire w_chan    = reg_wr && reg_addr == mcs_pkg::ADR_CHAN;
    wire w_store   = reg_wr && reg_addr == mcs_pkg::ADR_STORE;
    wire bit_start = start_ctl[mcs_pkg::START_BIT];
    wire one_tone  = start_ctl[mcs_pkg::ONE_TONE_BIT];
    wire pe_s      = pe_sy[1];
    wire cal_s     = cal_sy[1];
    wire cal_rise  = cal_sy[1] && !cal_sy[2];
    wire bit_rise  = w_start && reg_wdata[mcs_pkg::START_BIT] && !bit_start;
    wire pin_go    = cal_rise && !bit_start;
    wire run_cond  = src_pin ? cal_s : bit_start;
    wire [9:0] ms  = tif.ms;
    wire win1      = in_win(ms, mcs_pkg::T_ST1_MS, mcs_pkg::T_ET1_MS);
    wire win2      = in_win(ms, mcs_pkg::T_ST2_MS, mcs_pkg::T_ET2_MS);
    wire win3      = in_win(ms, mcs_pkg::T_ST3_MS, mcs_pkg::T_ET3_MS);
    wire meas_take = mv_sy[1] && !mv_sy[2];
    wire take_ok   = meas_take && st == mcs_pkg::ST_RUN;
    wire cal_end   = st == mcs_pkg::ST_RUN && ms >= mcs_pkg::T_CC_MS;
    wire manual_go = w_store && !reg_wdata[mcs_pkg::STROBE_N_BIT]
                     && store_ctl[mcs_pkg::STROBE_N_BIT]
                     && pe_s && aux_sy[1];
    wire strobe_up = w_store && reg_wdata[mcs_pkg::STROBE_N_BIT];

    assign tif.run = st == mcs_pkg::ST_RUN;

    // Sequencer; a dropped start before 790 ms aborts without commit
    always_comb begin
        next_st = st;
        case (st)
            mcs_pkg::ST_IDLE: begin
                if (pin_go || bit_rise) begin
                    next_st = mcs_pkg::ST_RUN;
                end else if (manual_go) begin
                    next_st = mcs_pkg::ST_STORE;
                end
            end
            mcs_pkg::ST_RUN: begin
                if (!run_cond) begin
                    next_st = mcs_pkg::ST_IDLE;
                end else if (cal_end) begin
                    next_st = permit_ok ? mcs_pkg::ST_STORE
                                        : mcs_pkg::ST_DONE;
                end
            end
            mcs_pkg::ST_DONE: begin
                if (!run_cond) begin
                    next_st = mcs_pkg::ST_IDLE;
                end
            end
            mcs_pkg::ST_STORE: begin
                if (nvm_prog_done) begin
                    next_st = mcs_pkg::ST_DONE;
                end
            end
            default: next_st = mcs_pkg::ST_IDLE;
        endcase
    end

    // State, start source and permit tracking over the whole run
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st        <= mcs_pkg::ST_IDLE;
            src_pin   <= 1'b0;
            permit_ok <= 1'b0;
        end else begin
            st <= next_st;
            if (st == mcs_pkg::ST_IDLE) begin
                src_pin   <= pin_go;
                permit_ok <= pe_s;
            end else if (st == mcs_pkg::ST_RUN && !pe_s) begin
                permit_ok <= 1'b0;
            end
        end
    end

    // Results per window; gaps and out-of-window input dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_n || st == mcs_pkg::ST_IDLE) begin
            res_band <= band;
            res_chan <= chan;
        end else if (take_ok && win1) begin
            res_chan <= mc_s2;
        end else if (take_ok && win2) begin
            res_band[7:4] <= mc_s2[3:0];
        end else if (take_ok && win3) begin
            res_band[3:0] <= mc_s2[3:0];
        end
    end

    // Register file; commit at sequence end takes priority
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            start_ctl <= mcs_pkg::START_RST;
            band      <= mcs_pkg::COMP_RST;
            chan      <= mcs_pkg::COMP_RST;
            store_ctl <= mcs_pkg::STORE_RST;
        end else begin
            if (w_start) begin
                start_ctl <= {6'h00, reg_wdata[1:0]};
            end
            if (cal_end && run_cond) begin
                chan <= res_chan;
                if (!one_tone) begin
                    band <= res_band;
                end
            end else begin
                if (w_band) begin
                    band <= reg_wdata;
                end
                if (w_chan) begin
                    chan <= reg_wdata;
                end
            end
            if (w_store) begin
                store_ctl <= reg_wdata;
            end
        end
    end

    // Ready flag: set by completion wins over the host's restore
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else if (st == mcs_pkg::ST_STORE && nvm_prog_done) begin
            ready <= 1'b1;
        end else if (strobe_up || next_st == mcs_pkg::ST_STORE) begin
            ready <= 1'b0;
        end
    end

    // Read data mux, unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            mcs_pkg::ADR_STATUS: rd_mux = {ready, TRIM_INIT};
            mcs_pkg::ADR_BAND:   rd_mux = band;
            mcs_pkg::ADR_CHAN:   rd_mux = chan;
            mcs_pkg::ADR_STORE:  rd_mux = store_ctl;
            mcs_pkg::ADR_START:  rd_mux = start_ctl;
            default:             rd_mux = 8'h00;
        endcase
    end

    // Store entry marker; kick waits one cycle so the commit has landed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            in_store_d <= 1'b0;
        end else begin
            in_store_d <= st == mcs_pkg::ST_STORE;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata          <= 8'h00;
            nvm_prog_start     <= 1'b0;
            nvm_write_strobe_n <= 1'b1;
            nvm_wr_data        <= 16'h0000;
            cal_active         <= 1'b0;
        end else begin
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
            nvm_prog_start <= st == mcs_pkg::ST_STORE
                              && !in_store_d;
            nvm_write_strobe_n <= store_ctl[mcs_pkg::STROBE_N_BIT];
            nvm_wr_data        <= {band, chan};
            cal_active         <= st == mcs_pkg::ST_RUN;
        end
    end

    // Checks
    sequence s_run_end_kept;
        st == mcs_pkg::ST_RUN && cal_end && run_cond;
    endsequence
    sequence s_store_kick;
        st == mcs_pkg::ST_STORE ##1 nvm_prog_start;
    endsequence

    pin_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st == mcs_pkg::ST_IDLE && pin_go |=> st == mcs_pkg::ST_RUN && src_pin)
        else $error("pin request did not start calibration");
    reg_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st == mcs_pkg::ST_RUN && !src_pin && bit_start && !cal_end
        |=> st == mcs_pkg::ST_RUN)
        else $error("engine left run while start bit held");
    pin_masked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st == mcs_pkg::ST_IDLE && cal_rise && bit_start && !w_start
        |=> st == mcs_pkg::ST_IDLE)
        else $error("pin rise honoured while start bit set");
    gap_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st == mcs_pkg::ST_RUN && !(win1 || win2 || win3)
        |=> $stable(res_band) && $stable(res_chan))
        else $error("result changed outside tone windows");
    seq_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st == mcs_pkg::ST_RUN && ms >= mcs_pkg::T_CC_MS
        |=> st != mcs_pkg::ST_RUN)
        else $error("calibration ran past 790 ms");
    auto_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_run_end_kept and permit_ok |=> s_store_kick)
        else $error("no automatic store at sequence end");
    volatile_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_run_end_kept and !permit_ok
        |=> st == mcs_pkg::ST_DONE && !nvm_prog_start)
        else $error("stored without permit held");
    one_tone_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_run_end_kept and one_tone |=> $stable(band))
        else $error("band changed in one-tone mode");
    ready_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st == mcs_pkg::ST_STORE && nvm_prog_done |=> ready)
        else $error("ready not set on programming done");
endmodule : mcs_top

// ===== sim/mcs_nvm_model.sv
// Behavioural EEPROM programmer answering the sequencer's store requests
`timescale 1ns/1ps
module mcs_nvm_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        nvm_prog_start,
    input  wire logic [15:0] nvm_wr_data,
    input  wire logic [7:0]  busy_cycles,
    output logic             nvm_prog_done
);
    logic [7:0]  left;
    logic        busy;
    logic [15:0] cells;
    // Programming time set by the bench, so prompt and slow both occur
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy          <= 1'b0;
            left          <= 8'h00;
            cells         <= 16'h0000;
            nvm_prog_done <= 1'b0;
        end else begin
            nvm_prog_done <= 1'b0;
            if (nvm_prog_start && !busy) begin
                busy  <= 1'b1;
                left  <= busy_cycles;
                cells <= nvm_wr_data;
            end else if (busy && left == 8'h00) begin
                busy          <= 1'b0;
                nvm_prog_done <= 1'b1;
            end else if (busy) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule : mcs_nvm_model

// ===== sim/mcs_top_tb.sv
// Self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module mcs_top_tb;
    localparam int         CPM  = 10;
    localparam logic [6:0] TRIM = 7'h35;
    logic        sys_clk, rst_n, cal_request_pin, store_permit_pin;
    logic        aux_programming_pin, meas_valid, reg_wr, reg_rd;
    logic        nvm_prog_done, nvm_prog_start, nvm_write_strobe_n;
    logic        cal_active;
    logic [7:0]  meas_code, reg_addr, reg_wdata, reg_rdata, busy;
    logic [7:0]  c1, c2, c3;
    logic [15:0] nvm_wr_data;
    logic [31:0] seed;
    logic [15:0] rd_q[$];
    logic [15:0] nv_q[$];
    int          error_cnt, checked;
    time         t0;

    mcs_top #(.CYC_PER_MS(CPM), .TRIM_INIT(TRIM)) u_mcs_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .cal_request_pin(cal_request_pin),
        .store_permit_pin(store_permit_pin), .meas_valid(meas_valid),
        .aux_programming_pin(aux_programming_pin), .meas_code(meas_code),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .nvm_prog_done(nvm_prog_done), .nvm_prog_start(nvm_prog_start),
        .nvm_write_strobe_n(nvm_write_strobe_n),
        .nvm_wr_data(nvm_wr_data), .cal_active(cal_active));
    mcs_nvm_model u_mcs_nvm_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .nvm_prog_start(nvm_prog_start),
        .nvm_wr_data(nvm_wr_data), .busy_cycles(busy),
        .nvm_prog_done(nvm_prog_done));

    // Xorshift source, fixed seed for repeatable runs
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic oops(input string m);
        error_cnt++;
        $display("[ERR] %0t %s", $time, m);
    endtask : oops
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) oops($sformatf("seen %h expected %h", seen, exp));
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
    endtask : wr
    // Read note goes in first; the monitor compares the answer later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back({8'h00, e});
        cyc(1);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
    endtask : rd
    // Wait until the given ms after the run started
    task automatic at_ms(input int ms);
        while ($time < t0 + ms * CPM * 10) @(posedge sys_clk);
        #1;
    endtask : at_ms
    // Code held steady across the whole strobe, as the sync needs
    task automatic meas(input logic [7:0] c);
        meas_code = c;
        cyc(1);
        meas_valid = 1'b1;
        cyc(4);
        meas_valid = 1'b0;
    endtask : meas
    task automatic wrap_up();
        if (nv_q.size() != 0) oops("store request missing");
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        oops("timeout");
        wrap_up();
    end
    // Output watcher: each result takes the oldest note
    initial begin : monitor
        logic rd_seen;
        rd_seen = 1'b0;
        forever begin
            @(posedge sys_clk);
            rd_seen = reg_rd;
            #2;
            if (rd_seen) chk({8'h00, reg_rdata}, rd_q.pop_front());
            if (nvm_prog_start === 1'b1 && nv_q.size() == 0) begin
                oops("unexpected store");
            end else if (nvm_prog_start === 1'b1) begin
                chk(nvm_wr_data, nv_q.pop_front());
            end
        end
    end

    initial begin : driver
        int tm[7];
        tm = '{5, 50, 205, 300, 405, 500, 650};
        seed = 32'd22241;
        {rst_n, cal_request_pin, store_permit_pin} = 3'h0;
        {aux_programming_pin, meas_valid, reg_wr, reg_rd} = 4'h0;
        {meas_code, reg_addr, reg_wdata} = 24'h000000;
        {error_cnt, checked, t0, busy} = '0;
        cyc(2);
        rst_n = 1'b1;
        rd(mcs_pkg::ADR_STATUS, {1'b0, TRIM});
        rd(mcs_pkg::ADR_BAND, mcs_pkg::COMP_RST);
        rd(mcs_pkg::ADR_CHAN, mcs_pkg::COMP_RST);
        rd(mcs_pkg::ADR_STORE, mcs_pkg::STORE_RST);
        rd(mcs_pkg::ADR_START, mcs_pkg::START_RST);
        rd(8'h20, 8'h00);
        // Register start, storing allowed, three tones and gap noise
        busy = 8'd3;
        store_permit_pin = 1'b1;
        meas(rnd());
        c1 = rnd();
        c2 = rnd();
        c3 = rnd();
        t0 = $time;
        wr(mcs_pkg::ADR_START, 8'h01);
        for (int i = 0; i < 7; i++) begin
            at_ms(tm[i]);
            meas(i == 1 ? c1 : i == 3 ? c2 : i == 5 ? c3 : rnd());
        end
        cal_request_pin = 1'b1;
        at_ms(680);
        cal_request_pin = 1'b0;
        chk(16'(cal_active), 16'h0001);
        nv_q.push_back({c2[3:0], c3[3:0], c1});
        at_ms(800);
        chk(16'(cal_active), 16'h0000);
        rd(mcs_pkg::ADR_STATUS, {1'b1, TRIM});
        rd(mcs_pkg::ADR_BAND, {c2[3:0], c3[3:0]});
        rd(mcs_pkg::ADR_CHAN, c1);
        wr(mcs_pkg::ADR_START, 8'h00);
        // Pin start, one tone, storing not allowed
        store_permit_pin = 1'b0;
        wr(mcs_pkg::ADR_START, 8'h02);
        meas(rnd());
        c1 = rnd();
        t0 = $time;
        cal_request_pin = 1'b1;
        at_ms(50);
        meas(c1);
        at_ms(300);
        meas(rnd());
        chk(16'(cal_active), 16'h0001);
        at_ms(800);
        rd(mcs_pkg::ADR_CHAN, c1);
        rd(mcs_pkg::ADR_BAND, {c2[3:0], c3[3:0]});
        cal_request_pin = 1'b0;
        wr(mcs_pkg::ADR_START, 8'h00);
        // Manual settings, slow programming, read-only status
        c1 = rnd();
        c2 = rnd();
        wr(mcs_pkg::ADR_BAND, c1);
        wr(mcs_pkg::ADR_CHAN, c2);
        rd(mcs_pkg::ADR_BAND, c1);
        rd(mcs_pkg::ADR_CHAN, c2);
        busy = 8'd200;
        store_permit_pin = 1'b1;
        aux_programming_pin = 1'b1;
        cyc(3);
        nv_q.push_back({c1, c2});
        wr(mcs_pkg::ADR_STORE, {1'b0, TRIM});
        cyc(3);
        chk(16'(nvm_write_strobe_n), 16'h0000);
        cyc(250);
        rd(mcs_pkg::ADR_STATUS, {1'b1, TRIM});
        wr(mcs_pkg::ADR_STATUS, 8'h00);
        rd(mcs_pkg::ADR_STATUS, {1'b1, TRIM});
        wr(mcs_pkg::ADR_STORE, 8'h80);
        rd(mcs_pkg::ADR_STATUS, {1'b0, TRIM});
        chk(16'(nvm_write_strobe_n), 16'h0001);
        store_permit_pin = 1'b0;
        aux_programming_pin = 1'b0;
        cyc(4);
        wrap_up();
    end
endmodule : mcs_top_tb
